// ---- hdl/ssp_core.sv ----
// SPI serial port core: shift engine, buffer, flags and pin control
`timescale 1ns/1ps
module ssp_core
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // Control and status
  input  wire logic [3:0] mode_in,
  input  wire logic       port_enable_bit_in,
  input  wire logic       clock_idle_polarity_in,
  input  wire logic       clock_edge_in,
  input  wire logic       input_sample_phase_in,
  input  wire logic [7:0] rate_reload_reg_in,
  input  wire logic       timer_tick_in,
  input  wire logic       write_collision_flag_clear_in,
  // Data buffer access
  input  wire logic       buf_wr_in,
  input  wire logic [7:0] buf_wdata_in,
  input  wire logic       buf_rd_in,
  output logic [7:0]      data_buffer_reg_out,
  // Flags
  output logic            buffer_full_flag_out,
  output logic            port_irq_flag_out,
  output logic            write_collision_flag_out,
  output logic            busy_out,
  // Serial pins
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_out,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  output logic            sdo_oe_out,
  input  wire logic       ss_n_in
);
  typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_state_e;
  ssp_state_e state_reg;
  ssp_state_e state_next;
  logic [7:0] shift_reg;
  logic [7:0] buf_reg;
  logic [2:0] cnt_reg;
  logic       sck_reg;
  logic       sample_reg;
  logic       bf_reg;
  logic       irq_reg;
  logic       write_collision_flag_reg;
  logic       sck_s;
  logic       sdi_s;
  logic       ss_n_s;
  logic       sck_d_reg;
  logic       half_tick;
  // Pin inputs pass two flops before use
  ssp_sync2 u_sync_sck (.mclk_in(mclk_in), .rst_in(rst_in), .d_in(sck_in), .q_out(sck_s));
  ssp_sync2 u_sync_sdi (.mclk_in(mclk_in), .rst_in(rst_in), .d_in(sdi_in), .q_out(sdi_s));
  ssp_sync2 u_sync_ss  (.mclk_in(mclk_in), .rst_in(rst_in), .d_in(ss_n_in), .q_out(ss_n_s));
  // Decode
  logic is_master;
  logic sel_mode;
  logic slave_sel;
  logic mod_reset;
  logic m_busy;
  logic run;
  assign is_master = (mode_in == SSP_M_DIV4) || (mode_in == SSP_M_DIV16) ||
                     (mode_in == SSP_M_DIV64) || (mode_in == SSP_M_TMR) ||
                     (mode_in == SSP_M_RELOAD);
  assign sel_mode  = (mode_in == SSP_S_SEL);
  assign slave_sel = !sel_mode || !ss_n_s;
  assign mod_reset = !port_enable_bit_in || (sel_mode && ss_n_s);
  assign m_busy    = (state_reg != SSP_IDLE);
  assign run       = port_enable_bit_in && is_master && m_busy;
  ssp_rate_gen u_rate (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .run_in        (run),
    .mode_in       (mode_in),
    .reload_in     (rate_reload_reg_in),
    .timer_tick_in (timer_tick_in),
    .half_tick_out (half_tick)
  );
  // Slave edge detect on synchronised clock; polarity and edge pick shift/capture
  logic s_rise;
  logic s_fall;
  logic s_lead;
  logic s_trail;
  logic s_active;
  assign s_rise   = sck_s && !sck_d_reg;
  assign s_fall   = !sck_s && sck_d_reg;
  // Leading edge leaves idle level; trailing returns to it
  assign s_lead   = clock_idle_polarity_in ? s_fall : s_rise;
  assign s_trail  = clock_idle_polarity_in ? s_rise : s_fall;
  assign s_active = port_enable_bit_in && !is_master && slave_sel;
  // Clock-edge bit high: data changes on trailing edge, captured on leading
  logic s_cap;
  logic s_shift;
  assign s_cap   = s_active && (clock_edge_in ? s_lead : s_trail);
  assign s_shift = s_active && (clock_edge_in ? s_trail : s_lead);
  // Master events per half period
  logic m_lead;
  logic m_trail;
  assign m_lead  = run && half_tick && (state_reg == SSP_LEAD);
  assign m_trail = run && half_tick && (state_reg == SSP_TRAIL);
  logic cap_ev;
  logic shf_ev;
  logic last_bit;
  logic byte_done;
  logic wr_ok;
  logic collide;
  assign cap_ev  = is_master ? (clock_edge_in ? m_lead : m_trail) : s_cap;
  assign shf_ev  = is_master ? (clock_edge_in ? m_trail : m_lead) : s_shift;
  assign last_bit = (cnt_reg == SSP_CNT_LAST);
  // Byte completes on the trailing edge of the last bit in both roles; input_sample_phase_in is not used
  assign byte_done = is_master ? (m_trail && last_bit) : (s_trail && s_active && last_bit);
  assign busy_out  = is_master ? m_busy : (cnt_reg != SSP_CNT_ZERO);
  assign collide   = buf_wr_in && port_enable_bit_in && (busy_out || write_collision_flag_reg);
  assign wr_ok     = buf_wr_in && port_enable_bit_in && !busy_out && !write_collision_flag_reg;
  // Master state: leading half then trailing half per bit
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SSP_IDLE:  if (wr_ok && is_master) state_next = SSP_LEAD;
      SSP_LEAD:  if (m_lead) state_next = SSP_TRAIL;
      SSP_TRAIL: if (m_trail) state_next = last_bit ? SSP_IDLE : SSP_LEAD;
      default:   state_next = SSP_IDLE;
    endcase
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !port_enable_bit_in)
      state_reg <= SSP_IDLE;
    else
      state_reg <= state_next;
  end
  // Master clock: toggles on each half tick, idle level otherwise
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || state_reg == SSP_IDLE)
      sck_reg <= 1'b0;
    else if (m_lead || m_trail)
      sck_reg <= m_lead;
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      sck_d_reg <= 1'b0;
    else
      sck_d_reg <= sck_s;
  end
  // Bit counter
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || mod_reset)
      cnt_reg <= SSP_CNT_ZERO;
    else if (is_master ? m_trail : (s_trail && s_active))
      cnt_reg <= 3'(cnt_reg + 3'h1);
  end
  // Shift register: capture into sample, shift out MSB first and take sample as LSB
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      sample_reg <= 1'b0;
    else if (cap_ev)
      sample_reg <= sdi_s;
  end
  // Last-bit capture folds sample into byte at completion
  logic [7:0] done_byte;
  assign done_byte = {shift_reg[6:0], (cap_ev ? sdi_s : sample_reg)};
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      shift_reg <= SSP_RST_BYTE;
    else if (wr_ok)
      shift_reg <= buf_wdata_in;
    else if (byte_done)
      shift_reg <= done_byte;
    // Leading-edge shift skips bit 0: the MSB is already out from the load
    else if (shf_ev && (clock_edge_in || cnt_reg != SSP_CNT_ZERO))
      shift_reg <= {shift_reg[6:0], sample_reg};
    else if (shf_ev && !is_master && cnt_reg == SSP_CNT_ZERO && clock_edge_in)
      shift_reg <= shift_reg;
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      buf_reg <= SSP_RST_BYTE;
    else if (wr_ok)
      buf_reg <= buf_wdata_in;
    else if (byte_done)
      buf_reg <= done_byte;
  end
  // Flags: hardware set wins over software clear
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      bf_reg   <= 1'b0;
      irq_reg  <= 1'b0;
      write_collision_flag_reg <= 1'b0;
    end
    else
    begin
      if (byte_done)
        bf_reg <= 1'b1;
      else if (buf_rd_in)
        bf_reg <= 1'b0;
      if (byte_done)
        irq_reg <= 1'b1;
      else if (buf_rd_in)
        irq_reg <= 1'b0;
      if (collide)
        write_collision_flag_reg <= 1'b1;
      else if (write_collision_flag_clear_in)
        write_collision_flag_reg <= 1'b0;
    end
  end
  // Pins
  assign sck_out    = sck_reg ^ clock_idle_polarity_in;
  assign sck_oe_out = port_enable_bit_in && is_master;
  assign sdo_out    = shift_reg[7];
  assign sdo_oe_out = port_enable_bit_in && (is_master || slave_sel);
  assign data_buffer_reg_out      = buf_reg;
  assign buffer_full_flag_out     = bf_reg;
  assign port_irq_flag_out        = irq_reg;
  assign write_collision_flag_out = write_collision_flag_reg;
  // Checks
  a_write_collision_flag_on_busy: assert property (@(posedge mclk_in) disable iff (rst_in)
    buf_wr_in && port_enable_bit_in && busy_out |=> write_collision_flag_reg)
    else $error("busy write did not set collision");
  a_write_collision_flag_blocks: assert property (@(posedge mclk_in) disable iff (rst_in)
    write_collision_flag_reg && buf_wr_in |=> $stable(buf_reg) || $past(byte_done))
    else $error("write passed while collision set");
  a_bf_on_done: assert property (@(posedge mclk_in) disable iff (rst_in)
    byte_done |=> bf_reg && irq_reg && buf_reg == $past(done_byte))
    else $error("byte completion did not load buffer");
  a_bf_read_clr: assert property (@(posedge mclk_in) disable iff (rst_in)
    buf_rd_in && !byte_done |=> !bf_reg)
    else $error("read did not clear full flag");
  a_write_loads: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_ok |=> shift_reg == $past(buf_wdata_in) && buf_reg == $past(buf_wdata_in))
    else $error("write did not load both registers");
  a_idle_clock: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_reg == SSP_IDLE ##1 state_reg == SSP_IDLE |-> sck_out == clock_idle_polarity_in)
    else $error("idle clock not at idle level");
  a_sel_release: assert property (@(posedge mclk_in) disable iff (rst_in)
    sel_mode && ss_n_s |-> !sdo_oe_out)
    else $error("data driven while deselected");
  a_modreset_cnt: assert property (@(posedge mclk_in) disable iff (rst_in)
    mod_reset |=> cnt_reg == SSP_CNT_ZERO)
    else $error("module reset did not zero counter");
  a_disabled_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    !port_enable_bit_in |-> !sck_oe_out && !sdo_oe_out)
    else $error("pins driven while disabled");
  c_master_byte: cover property (@(posedge mclk_in) disable iff (rst_in) is_master && byte_done);
  c_slave_byte:  cover property (@(posedge mclk_in) disable iff (rst_in) !is_master && byte_done);
  c_collision:   cover property (@(posedge mclk_in) disable iff (rst_in) collide);
endmodule

// ---- hdl/ssp_pkg.sv ----
// Constants for the synchronous serial port block
// Operation
// - Eight-bit shift register sends MSB first while new LSB enters same clock.
// - Output bits change on configured edge; input captured on opposite edge.
// - After eight serial clocks master and slave registers have swapped contents.
// - Unselected slave ignores clock and data and drives nothing.
// - After eight bits, byte moves to buffer; buffer-full and irq flags set.
// - Buffered receive lets next byte shift before software reads previous.
// - Data buffer write loads buffer and shift register together.
// - Buffer write during shifting is discarded and sets write-collision flag.
// - Writes stay rejected until software clears write-collision flag.
// - Software read of data buffer clears buffer-full flag.
// - Shift register reachable only through data buffer reads and writes.
// - Status low six bits read-only, upper two writable; control fully writable.
// - Control low field and status top bits choose mode, polarity, phase, edge, rate; the core ignores phase (input_sample_phase_in unused).
// - Master drives serial clock; slave takes serial clock from master.
// - Enable turns on port pins; reconfigure by disabling, rewriting, enabling.
// - In one master mode the reload register sets the baud generator rate.
// - Master rate: clock/4, /16, /64, timer/2, or clock/(4*(reload+1)); reload bit 7 is ignored, so 0x80-0xff act as reload-128.
// - Mode 0100 drives data-out only while select low, releases on high.
// - Select high in mode 0100, or disable, forces bit counter to zero.
package ssp_pkg;
  localparam int          SSP_BITS       = 8;
  localparam logic [3:0]  SSP_M_DIV4     = 4'h0;
  localparam logic [3:0]  SSP_M_DIV16    = 4'h1;
  localparam logic [3:0]  SSP_M_DIV64    = 4'h2;
  localparam logic [3:0]  SSP_M_TMR      = 4'h3;
  localparam logic [3:0]  SSP_S_SEL      = 4'h4;
  localparam logic [3:0]  SSP_S_NOSEL    = 4'h5;
  localparam logic [3:0]  SSP_M_RELOAD   = 4'ha;
  localparam int          SSP_CTL_MODE_LSB = 0;
  localparam int          SSP_CTL_CKP    = 4;
  localparam int          SSP_CTL_EN     = 5;
  localparam int          SSP_CTL_WRITE_COLLISION_FLAG   = 7;
  localparam int          SSP_ST_BF      = 0;
  localparam int          SSP_ST_CKE     = 6;
  localparam int          SSP_ST_SMP     = 7;
  localparam logic [7:0]  SSP_RST_BYTE   = 8'h00;
  localparam logic [2:0]  SSP_CNT_ZERO   = 3'h0;
  localparam logic [2:0]  SSP_CNT_LAST   = 3'h7;
endpackage

// ---- hdl/ssp_rate_gen.sv ----
// Master serial clock rate generator, gives half-bit ticks
`timescale 1ns/1ps
module ssp_rate_gen
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [3:0] mode_in,
  input  wire logic [7:0] reload_in,
  input  wire logic       timer_tick_in,
  // Tick
  output logic            half_tick_out
);
  // Half serial period in clocks: full period /2
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] limit;
  logic       reached;
  // Full period = 4(R+1) so half = 2(R+1); reload bit 7 is dropped, so reloads 0x80-0xff act as R-128
  // Limitation: at two clocks a half the synced input lags half a bit; peer must be fast
  assign limit = (mode_in == SSP_M_DIV16) ? 8'h07 :
                 (mode_in == SSP_M_DIV64) ? 8'h1f :
                 (mode_in == SSP_M_RELOAD) ? {reload_in[6:0], 1'b1} : 8'h01;
  assign reached  = (cnt_reg >= limit);
  assign cnt_next = reached ? 8'h00 : 8'(cnt_reg + 8'h01);
  // Timer mode: one half-bit per timer tick gives timer/2 rate
  assign half_tick_out = run_in && ((mode_in == SSP_M_TMR) ? timer_tick_in : reached);
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !run_in)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end
endmodule

// ---- hdl/ssp_sync2.sv ----
// Two-flop synchroniser for a pin input
`timescale 1ns/1ps
module ssp_sync2
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Data
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end
    else
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// ---- tb/ssp_peer_model.sv ----
// Behavioural external SPI slave facing the port in master mode
`timescale 1ns/1ps
module ssp_peer_model
(
  // Serial lines
  input  wire logic       sck_in,
  input  wire logic       ss_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  // Byte to send and byte shifted in
  input  wire logic [7:0] load_in,
  output logic [7:0]      shift_out
);
  logic bit_q;

  initial shift_out = 8'h00;
  initial bit_q = 1'b0;

  // Released line shows the inverse, so a stale bit never passes
  assign miso_out = ss_n_in ? ~shift_out[7] : shift_out[7];

  always @(negedge ss_n_in)
  begin
    shift_out = load_in;
  end

  // Capture on rising, change on falling: the mode the bench sets
  always @(posedge sck_in)
  begin
    if (!ss_n_in)
      bit_q = mosi_in;
  end

  // MSB out, new LSB in; eight clocks swap the bytes
  always @(negedge sck_in)
  begin
    if (!ss_n_in)
      shift_out = {shift_out[6:0], bit_q};
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the serial port core in master and select-controlled slave modes
`timescale 1ns/1ps
module tb;
  import ssp_pkg::*;
  typedef struct {logic [3:0] m; logic [7:0] r; logic [7:0] tx; logic [7:0] rx;} ssp_row_s;

  logic       clk = 0, rst = 1, en = 0, clock_idle_polarity = 0, cke = 1, tick = 0, wclr = 0;
  logic       wr = 0, rd = 0, sel_n = 1, ssck = 0;
  logic [3:0] mode = SSP_M_DIV16, tcnt = 4'h0;
  logic [7:0] reload = 8'h00, wdata = 8'h00, ld = 8'h00;
  logic [7:0] rbuf, pshift;
  logic       bf, irq, write_collision_flag, busy, sck, sck_oe, sdo, sdo_oe, miso, sck_w;
  int         n_errors = 0, checks_done = 0;
  ssp_row_s   rows [5];

  always #50 clk = ~clk;
  always @(posedge clk) tcnt <= tcnt + 4'h1;
  always @(posedge clk) tick <= (tcnt == 4'h0);
  assign sck_w = sck_oe ? sck : (clock_idle_polarity ^ ssck);

  ssp_core dut
  (
    .mclk_in(clk), .rst_in(rst), .mode_in(mode), .port_enable_bit_in(en),
    .clock_idle_polarity_in(clock_idle_polarity), .clock_edge_in(cke), .input_sample_phase_in(1'b0),
    .rate_reload_reg_in(reload), .timer_tick_in(tick), .write_collision_flag_clear_in(wclr),
    .buf_wr_in(wr), .buf_wdata_in(wdata), .buf_rd_in(rd), .data_buffer_reg_out(rbuf),
    .buffer_full_flag_out(bf), .port_irq_flag_out(irq), .write_collision_flag_out(write_collision_flag),
    .busy_out(busy), .sck_in(sck_w), .sck_out(sck), .sck_oe_out(sck_oe), .sdi_in(miso),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .ss_n_in(sel_n)
  );

  ssp_peer_model peer
  (
    .sck_in(sck_w), .ss_n_in(sel_n), .mosi_in(sdo), .miso_out(miso),
    .load_in(ld), .shift_out(pshift)
  );

  task automatic close_out();
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse_wr(input logic [7:0] b);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= b;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) rd <= 1'b1;
    else wclr <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    wclr <= 1'b0;
  endtask

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_idle();
    int i;
    tick_clk(2);
    for (i = 0; i < 4000 && busy !== 1'b0; i++) tick_clk(1);
    if (busy !== 1'b0)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b0);
      close_out();
    end
    tick_clk(1);
  endtask

  // Mode changes only while disabled
  task automatic cfg(input logic [3:0] m, input logic [7:0] r);
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    mode <= m;
    reload <= r;
    @(posedge clk);
    en <= 1'b1;
  endtask

  initial
  begin
    rows[0] = '{SSP_M_DIV16, 8'h00, 8'ha5, 8'h3c};
    rows[1] = '{SSP_M_DIV64, 8'h00, 8'h81, 8'h7e};
    rows[2] = '{SSP_M_TMR, 8'h00, 8'h00, 8'hff};
    rows[3] = '{SSP_M_RELOAD, 8'h03, 8'h5a, 8'hc3};
    rows[4] = '{SSP_M_RELOAD, 8'h01, 8'hff, 8'h01};
    tick_clk(5);
    rst <= 1'b0;
    tick_clk(3);
    chk({6'h00, bf, irq}, 8'h00);
    chk(rbuf, SSP_RST_BYTE);
    chk({7'h00, sck}, {7'h00, clock_idle_polarity});
    foreach (rows[k])
    begin
      cfg(rows[k].m, rows[k].r);
      ld <= rows[k].rx;
      sel_n <= 1'b0;
      pulse_wr(rows[k].tx);
      wait_idle();
      chk(rbuf, rows[k].rx);
      chk(pshift, rows[k].tx);
      chk({6'h00, bf, irq}, 8'h03);
      @(posedge clk);
      sel_n <= 1'b1;
      pulse(0);
      tick_clk(1);
      chk({6'h00, bf, irq}, 8'h00);
    end
    // Write during shifting, then while the collision flag stands
    cfg(SSP_M_DIV16, 8'h00);
    ld <= 8'h11;
    sel_n <= 1'b0;
    pulse_wr(8'haa);
    pulse_wr(8'h55);
    tick_clk(1);
    chk({7'h00, write_collision_flag}, 8'h01);
    wait_idle();
    chk(pshift, 8'haa);
    chk(rbuf, 8'h11);
    pulse(0);
    pulse_wr(8'h66);
    tick_clk(2);
    chk({6'h00, busy, write_collision_flag}, 8'h01);
    pulse(1);
    tick_clk(1);
    chk({7'h00, write_collision_flag}, 8'h00);
    // Next byte with no read between: echo of the last one
    pulse_wr(8'h66);
    wait_idle();
    chk(rbuf, 8'haa);
    chk(pshift, 8'h66);
    pulse_wr(8'h99);
    wait_idle();
    chk(rbuf, 8'h66);
    chk({7'h00, bf}, 8'h01);
    // Disabled port: pins released, writes and flags frozen
    @(posedge clk);
    en <= 1'b0;
    clock_idle_polarity <= 1'b1;
    sel_n <= 1'b1;
    pulse_wr(8'h42);
    tick_clk(2);
    chk({5'h00, sck_oe, sdo_oe, busy}, 8'h00);
    chk({7'h00, bf}, 8'h01);
    @(posedge clk);
    en <= 1'b1;
    tick_clk(2);
    chk({6'h00, sck_oe, sck}, 8'h03);
    clock_idle_polarity <= 1'b0;
    // Select-controlled slave with select high drives nothing
    cfg(SSP_S_SEL, 8'h00);
    tick_clk(4);
    chk({6'h00, sck_oe, sdo_oe}, 8'h00);
    // Slave exchange, bench makes the serial clock
    ld <= 8'h5c;
    sel_n <= 1'b0;
    pulse_wr(8'h3a);
    repeat (16)
    begin
      tick_clk(8);
      ssck <= ~ssck;
    end
    tick_clk(8);
    chk(rbuf, 8'h5c);
    chk(pshift, 8'h3a);
    chk({7'h00, sdo_oe}, 8'h01);
    sel_n <= 1'b1;
    tick_clk(4);
    chk({7'h00, sdo_oe}, 8'h00);
    close_out();
  end
endmodule
